/* core/lfosc_ctrl.sv */
// lfosc_ctrl: control of the internal ulp 32k oscillator and the external
// 32k crystal or clock oscillator, programmed over classic wishbone.
// assumes oscillator ticks and the crystal pin are synchronous to sys_clk_in
// and much slower than it; sleep mode and requests come from the system.
//
// Function
// - ulp keeps running when run-in-standby set
// - ulp output gated unless peripheral requests
// - ulp gate opens after 4 ticks
// - sel and startup locked while enabled or stable
// - startup field picks 1k/16k/32k/64k cycles
// - external clock source skips startup wait
// - source bit: 0 crystal, 1 clock in
// - crystal runs per run-in-standby and requests
// - crystal output gated unless peripheral requests
// - ready crystal delivers output within 2-3 cycles
// - enable takes pins, makes fields read-only
// - enable and standby bits need protection unlock
// - stable flag only when stable and requested
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps

module lfosc_ctrl #(
  parameter int ULP_STARTUP_TICKS = 8,
  parameter int XO_CYCLES_1K = 1024,
  parameter int XO_CYCLES_16K = 16384,
  parameter int XO_CYCLES_32K = 32768,
  parameter int XO_CYCLES_64K = 65536
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // system state and clock requests
  input wire logic [1:0] sleep_mode_in,
  input wire logic ulp_request_in,
  input wire logic xo_request_in,
  // oscillator sources
  input wire logic ulp_tick_in,
  input wire logic crystal_pin_in,
  // oscillator and gate controls
  output logic ulp_run_out,
  output logic ulp_clk_gate_out,
  output logic xo_run_out,
  output logic xo_clk_gate_out,
  output logic pin_override_out
);

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0] xo_ctrl;
  logic ulp_run_stby;
  logic [2:0] unlock_cnt;
  logic bus_req;
  logic wr_en;
  logic unlocked;
  logic fields_locked;
  logic xo_enable;
  logic xo_run_stby;
  logic xo_sel;
  logic [1:0] xo_crystal_startup_time;
  logic ulp_run;
  logic [7:0] ulp_cnt;
  logic ulp_ready;
  logic [2:0] ulp_gate_cnt;
  logic crystal_prev;
  logic xo_edge;
  logic xo_run;
  lfosc_pkg::lfosc_xo_state_t xo_state;
  lfosc_pkg::lfosc_xo_state_t next_xo_state;
  logic [16:0] xo_cnt;
  logic [16:0] xo_target;
  logic [1:0] xo_gate_cnt;
  logic xo_stable;
  logic [31:0] next_rd;

  assign xo_enable = xo_ctrl[lfosc_pkg::XO_ENABLE_BIT];
  assign xo_run_stby = xo_ctrl[lfosc_pkg::XO_RUN_STBY_BIT];
  assign xo_sel = xo_ctrl[lfosc_pkg::XO_SEL_BIT];
  assign xo_crystal_startup_time = xo_ctrl[lfosc_pkg::XO_CRYSTAL_STARTUP_TIME_MSB:lfosc_pkg::XO_CRYSTAL_STARTUP_TIME_LSB];

  //////////////////////////////////////////////////////////////////////////
  // wishbone handshake: ack one cycle after the request, dropped after

  assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_en = bus_req & wb_we_in & wb_sel_in[0];

  // single-cycle ack keeps the slave simple; every address answers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= bus_req;
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    next_rd = 32'h0000_0000;
    unique case (wb_adr_in)
      lfosc_pkg::XO_CTRL_ADDR: begin
        next_rd[7:0] = xo_ctrl;
      end
      lfosc_pkg::ULP_CTRL_ADDR: begin
        next_rd[lfosc_pkg::ULP_RUN_STBY_BIT] = ulp_run_stby;
      end
      lfosc_pkg::STATUS_ADDR: begin
        next_rd[lfosc_pkg::STAT_XO_BIT] = xo_stable;
        next_rd[lfosc_pkg::STAT_ULP_BIT] = ulp_ready & ulp_request_in;
      end
      default: begin
        next_rd = 32'h0000_0000;
      end
    endcase
  end

  // read data registered with the ack
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (bus_req && !wb_we_in) begin
      wb_dat_out <= next_rd;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration change protection

  // the key opens a short window; any protected write closes it again
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      unlock_cnt <= 3'h0;
    end else if (wr_en && wb_adr_in == lfosc_pkg::UNLOCK_ADDR &&
                 wb_dat_in[7:0] == lfosc_pkg::UNLOCK_KEY) begin
      unlock_cnt <= lfosc_pkg::UNLOCK_CYCLES;
    end else if (wr_en && (wb_adr_in == lfosc_pkg::XO_CTRL_ADDR ||
                           wb_adr_in == lfosc_pkg::ULP_CTRL_ADDR)) begin
      unlock_cnt <= 3'h0;
    end else if (unlock_cnt != 3'h0) begin
      unlock_cnt <= unlock_cnt - 3'h1;
    end
  end

  assign unlocked = (unlock_cnt != 3'h0);
  assign fields_locked = xo_enable | xo_stable;

  //////////////////////////////////////////////////////////////////////////
  // control registers

  // crystal control; locked fields keep their value, reserved stay zero
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xo_ctrl <= lfosc_pkg::XO_CTRL_RESET;
    end else if (wr_en && wb_adr_in == lfosc_pkg::XO_CTRL_ADDR) begin
      if (unlocked) begin
        xo_ctrl[lfosc_pkg::XO_ENABLE_BIT] <=
          wb_dat_in[lfosc_pkg::XO_ENABLE_BIT];
        xo_ctrl[lfosc_pkg::XO_RUN_STBY_BIT] <=
          wb_dat_in[lfosc_pkg::XO_RUN_STBY_BIT];
      end
      if (!fields_locked) begin
        xo_ctrl[lfosc_pkg::XO_SEL_BIT] <=
          wb_dat_in[lfosc_pkg::XO_SEL_BIT];
        xo_ctrl[lfosc_pkg::XO_CRYSTAL_STARTUP_TIME_MSB:lfosc_pkg::XO_CRYSTAL_STARTUP_TIME_LSB] <=
          wb_dat_in[lfosc_pkg::XO_CRYSTAL_STARTUP_TIME_MSB:lfosc_pkg::XO_CRYSTAL_STARTUP_TIME_LSB];
      end
    end
  end

  // ulp run-in-standby, also behind the protection window
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ulp_run_stby <= lfosc_pkg::ULP_RUN_STBY_RESET;
    end else if (wr_en && unlocked &&
                 wb_adr_in == lfosc_pkg::ULP_CTRL_ADDR) begin
      ulp_run_stby <= wb_dat_in[lfosc_pkg::ULP_RUN_STBY_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // internal ulp oscillator

  assign ulp_run = ulp_run_stby | ulp_request_in;

  // analog start-up only counts when the oscillator was stopped
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ulp_cnt <= 8'h00;
      ulp_ready <= 1'b0;
    end else if (!ulp_run) begin
      ulp_cnt <= 8'h00;
      ulp_ready <= 1'b0;
    end else if (ulp_run_stby) begin
      ulp_ready <= 1'b1;
    end else if (ulp_tick_in && !ulp_ready) begin
      if (ulp_cnt + 8'h01 >= 8'(ULP_STARTUP_TICKS)) begin
        ulp_ready <= 1'b1;
      end
      ulp_cnt <= ulp_cnt + 8'h01;
    end
  end

  // output gate: 4 ticks after request once running, shut on release
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ulp_gate_cnt <= 3'h0;
      ulp_clk_gate_out <= 1'b0;
    end else if (!ulp_request_in || !ulp_ready) begin
      ulp_gate_cnt <= 3'h0;
      ulp_clk_gate_out <= 1'b0;
    end else if (ulp_tick_in && !ulp_clk_gate_out) begin
      if (ulp_gate_cnt + 3'h1 == lfosc_pkg::ULP_GATE_TICKS) begin
        ulp_clk_gate_out <= 1'b1;
      end
      ulp_gate_cnt <= ulp_gate_cnt + 3'h1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ulp_run_out <= 1'b0;
    end else begin
      ulp_run_out <= ulp_run;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // external crystal oscillator

  // run-in-standby keeps it on except in power down; else on request
  assign xo_run = xo_enable &
    (xo_run_stby ? (sleep_mode_in != lfosc_pkg::MODE_PDOWN)
                 : xo_request_in);

  // one crystal cycle is one rising edge on the pin
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      crystal_prev <= 1'b0;
    end else begin
      crystal_prev <= crystal_pin_in;
    end
  end

  assign xo_edge = crystal_pin_in & ~crystal_prev;

  // start-up length chosen by the field
  always_comb begin
    xo_target = 17'(XO_CYCLES_1K);
    unique case (xo_crystal_startup_time)
      lfosc_pkg::CRYSTAL_STARTUP_TIME_1K: xo_target = 17'(XO_CYCLES_1K);
      lfosc_pkg::CRYSTAL_STARTUP_TIME_16K: xo_target = 17'(XO_CYCLES_16K);
      lfosc_pkg::CRYSTAL_STARTUP_TIME_32K: xo_target = 17'(XO_CYCLES_32K);
      lfosc_pkg::CRYSTAL_STARTUP_TIME_64K: xo_target = 17'(XO_CYCLES_64K);
    endcase
  end

  // start-up sequencing; a clock input is usable at once
  always_comb begin
    next_xo_state = xo_state;
    unique case (xo_state)
      lfosc_pkg::XO_OFF: begin
        if (xo_run) begin
          next_xo_state = (xo_sel == lfosc_pkg::SEL_EXT_CLOCK) ?
            lfosc_pkg::XO_READY : lfosc_pkg::XO_START;
        end
      end
      lfosc_pkg::XO_START: begin
        if (!xo_run) begin
          next_xo_state = lfosc_pkg::XO_OFF;
        end else if (xo_edge && xo_cnt + 17'h00001 >= xo_target) begin
          next_xo_state = lfosc_pkg::XO_READY;
        end
      end
      lfosc_pkg::XO_READY: begin
        if (!xo_run) begin
          next_xo_state = lfosc_pkg::XO_OFF;
        end
      end
      default: begin
        next_xo_state = lfosc_pkg::XO_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xo_state <= lfosc_pkg::XO_OFF;
    end else begin
      xo_state <= next_xo_state;
    end
  end

  // start-up counter restarts whenever the oscillator stops
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xo_cnt <= 17'h00000;
    end else if (xo_state != lfosc_pkg::XO_START) begin
      xo_cnt <= 17'h00000;
    end else if (xo_edge) begin
      xo_cnt <= xo_cnt + 17'h00001;
    end
  end

  // stable flag only while someone actually asks for the clock
  assign xo_stable = (xo_state == lfosc_pkg::XO_READY) & xo_request_in;

  // gate opens on the second edge once stable, giving two to three cycles
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xo_gate_cnt <= 2'h0;
      xo_clk_gate_out <= 1'b0;
    end else if (!xo_stable) begin
      xo_gate_cnt <= 2'h0;
      xo_clk_gate_out <= 1'b0;
    end else if (xo_edge && !xo_clk_gate_out) begin
      if (xo_gate_cnt + 2'h1 == lfosc_pkg::XO_GATE_EDGES) begin
        xo_clk_gate_out <= 1'b1;
      end
      xo_gate_cnt <= xo_gate_cnt + 2'h1;
    end
  end

  // pin takeover follows the enable bit alone
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xo_run_out <= 1'b0;
      pin_override_out <= 1'b0;
    end else begin
      xo_run_out <= xo_run;
      pin_override_out <= xo_enable;
    end
  end

endmodule

/* shared/lfosc_pkg.sv */
// lfosc_pkg: register map, field layout and timing constants for the
// low-frequency oscillator control block.
// assumes a 32-bit classic wishbone slave with byte addresses.
package lfosc_pkg;

  // register byte addresses (word aligned)
  localparam logic [7:0] ULP_CTRL_ADDR = 8'h18;
  localparam logic [7:0] XO_CTRL_ADDR = 8'h1c;
  localparam logic [7:0] STATUS_ADDR = 8'h20;
  localparam logic [7:0] UNLOCK_ADDR = 8'h24;

  // crystal_osc_control fields
  localparam int XO_ENABLE_BIT = 0;
  localparam int XO_RUN_STBY_BIT = 1;
  localparam int XO_SEL_BIT = 2;
  localparam int XO_CRYSTAL_STARTUP_TIME_LSB = 4;
  localparam int XO_CRYSTAL_STARTUP_TIME_MSB = 5;

  // ulp_osc_control fields
  localparam int ULP_RUN_STBY_BIT = 1;

  // main_clock_status_reg fields
  localparam int STAT_ULP_BIT = 5;
  localparam int STAT_XO_BIT = 6;

  // reset values
  localparam logic [7:0] XO_CTRL_RESET = 8'h00;
  localparam logic ULP_RUN_STBY_RESET = 1'b0;

  // start-up time field encodings
  localparam logic [1:0] CRYSTAL_STARTUP_TIME_1K = 2'h0;
  localparam logic [1:0] CRYSTAL_STARTUP_TIME_16K = 2'h1;
  localparam logic [1:0] CRYSTAL_STARTUP_TIME_32K = 2'h2;
  localparam logic [1:0] CRYSTAL_STARTUP_TIME_64K = 2'h3;

  // source select values
  localparam logic SEL_CRYSTAL = 1'b0;
  localparam logic SEL_EXT_CLOCK = 1'b1;

  // sleep mode encodings on the sleep_mode_in port
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_IDLE = 2'h1;
  localparam logic [1:0] MODE_STANDBY = 2'h2;
  localparam logic [1:0] MODE_PDOWN = 2'h3;

  // protection key and how long writes stay open after it
  localparam logic [7:0] UNLOCK_KEY = 8'hd8;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

  // oscillator-cycle delays before the output gate opens
  localparam logic [2:0] ULP_GATE_TICKS = 3'h4;
  localparam logic [1:0] XO_GATE_EDGES = 2'h2;

  // crystal start-up state
  typedef enum logic [1:0] {
    XO_OFF = 2'b00,
    XO_START = 2'b01,
    XO_READY = 2'b10
  } lfosc_xo_state_t;

endpackage

/* sim/lfosc_ctrl_monitor.sv */
// lfosc_ctrl_monitor: port-level checks on the 32k oscillator control.
// assumes one clock domain and an async active-low reset.
`timescale 1ns/100ps
module lfosc_ctrl_monitor (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // bus and system inputs
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic [1:0] sleep_mode_in,
  input wire logic ulp_request_in,
  input wire logic xo_request_in,
  input wire logic ulp_tick_in,
  // design outputs
  input wire logic wb_ack_out,
  input wire logic ulp_run_out,
  input wire logic ulp_clk_gate_out,
  input wire logic xo_run_out,
  input wire logic xo_clk_gate_out,
  input wire logic pin_override_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // bus answers one cycle after a request is taken, for one cycle
  a_ack_next_cycle: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
    |=> wb_ack_out ##1 !wb_ack_out) else $error("ack not one cycle late");
  // gates close one cycle after the request goes away
  a_ulp_gate_off: assert property
    (!ulp_request_in |=> !ulp_clk_gate_out)
    else $error("ulp gate open without request");
  a_xo_gate_off: assert property
    (!xo_request_in |=> !xo_clk_gate_out)
    else $error("crystal gate open without request");
  // the ulp gate only opens on an oscillator tick
  a_ulp_gate_tick: assert property
    ($rose(ulp_clk_gate_out) |-> $past(ulp_tick_in) && ulp_request_in)
    else $error("ulp gate opened off a tick");
  a_ulp_gate_run: assert property
    (ulp_clk_gate_out |-> ulp_run_out)
    else $error("ulp gate open while stopped");
  a_ulp_run_req: assert property
    (ulp_request_in |=> ulp_run_out)
    else $error("ulp not running on request");
  a_xo_gate_open: assert property
    ($rose(xo_clk_gate_out) |-> xo_request_in && xo_run_out)
    else $error("crystal gate opened while idle");
  // no pins, no crystal: both outputs lag the enable bit by one cycle,
  // so they are compared in the same cycle
  a_xo_needs_pins: assert property
    (!pin_override_out |-> !xo_run_out)
    else $error("crystal running while disabled");
  // power down stops an unrequested crystal
  a_xo_pdown_off: assert property
    (sleep_mode_in == 2'h3 && !xo_request_in |=> !xo_run_out)
    else $error("crystal running in power down");
endmodule
bind lfosc_ctrl lfosc_ctrl_monitor u_monitor (.*);

/* sim/lfosc_src_model.sv */
// lfosc_src_model: crystal on the pins plus the ulp oscillator ticks.
// assumes both are far slower than sys_clk_in, period 8 cycles here.
`timescale 1ns/100ps
module lfosc_src_model (
  // clock
  input wire logic sys_clk_in,
  // oscillator enable from the block
  input wire logic run_in,
  // outputs
  output logic pin_out,
  output logic tick_out
);
  logic [2:0] div = 3'h0;
  // a stopped crystal makes no edges, so the pin sits low
  assign pin_out = run_in & div[2];
  assign tick_out = (div == 3'h7);
  // free-running divider shared by both sources
  always @(posedge sys_clk_in) div <= div + 3'h1;
endmodule

/* sim/testbench.sv */
// testbench: drives lfosc_ctrl over wishbone and judges its outputs.
// assumes lfosc_src_model as crystal and ulp source; short start-up counts.
`timescale 1ns/100ps
module testbench;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0;
  logic [31:0] wb_dat_out, rd;
  logic [1:0] sleep_mode_in = 2'h0;
  logic ulp_request_in = 1'b0;
  logic xo_request_in = 1'b0;
  logic wb_ack_out, ulp_run_out, ulp_clk_gate_out, xo_run_out;
  logic xo_clk_gate_out, pin_override_out, ulp_tick_in, crystal_pin_in;
  int fails = 0;
  int comparisons = 0;
  always #12.5 sys_clk_in = ~sys_clk_in;
  // short counts keep the run brief: 4, 8, 12 and 16 crystal edges
  lfosc_ctrl #(.ULP_STARTUP_TICKS(2), .XO_CYCLES_1K(4), .XO_CYCLES_16K(8),
    .XO_CYCLES_32K(12), .XO_CYCLES_64K(16)) DUT (.*);
  lfosc_src_model u_src (.sys_clk_in(sys_clk_in), .run_in(xo_run_out),
    .pin_out(crystal_pin_in), .tick_out(ulp_tick_in));
  ////////////////////////////////////////
  task automatic final_report();
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle; read data lands in rd at the ack edge
  task automatic wb(input logic we, input logic [7:0] adr, dat);
    int n;
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= adr;
    wb_sel_in <= 4'h1;
    wb_dat_in <= {24'h0, dat};
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    rd = wb_dat_out;
    if (n >= 20) begin
      fails++;
      final_report();
    end
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  // protected write must follow the key straight away
  task automatic prot(input logic [7:0] adr, dat);
    wb(1'b1, lfosc_pkg::UNLOCK_ADDR, lfosc_pkg::UNLOCK_KEY);
    wb(1'b1, adr, dat);
  endtask
  // start just after a ulp tick so no edge sits on the request edge
  task automatic align();
    int n;
    n = 0;
    while (ulp_tick_in !== 1'b1 && n < 9) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (ulp_tick_in !== 1'b1) begin
      fails++;
      final_report();
    end
  endtask
  // waits for a gate (xo high: crystal, else ulp), counting crystal edges
  // and ulp ticks meanwhile
  task automatic wait_high(input logic xo, output int xe, te);
    logic p;
    int n;
    xe = 0;
    te = 0;
    p = crystal_pin_in;
    for (n = 0; n < 400 &&
         (xo ? xo_clk_gate_out : ulp_clk_gate_out) !== 1'b1; n++) begin
      @(posedge sys_clk_in);
      xe += int'(crystal_pin_in & ~p);
      te += int'(ulp_tick_in);
      p = crystal_pin_in;
    end
    if (n >= 400) begin
      fails++;
      final_report();
    end
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] a [5] = '{8'h18, 8'h1c, 8'h20, 8'h24, 8'h30};
    foreach (a[i]) begin
      wb(1'b0, a[i], 8'h00);
      chk("reset value", 32'h0, rd);
    end
    // no key: enable and standby bits stay clear, reserved read zero
    wb(1'b1, lfosc_pkg::XO_CTRL_ADDR, 8'hff);
    wb(1'b0, lfosc_pkg::XO_CTRL_ADDR, 8'h00);
    chk("unkeyed write", 32'h34, rd);
    // a key gone stale by the time of the write opens nothing
    wb(1'b1, lfosc_pkg::UNLOCK_ADDR, lfosc_pkg::UNLOCK_KEY);
    wb(1'b0, lfosc_pkg::STATUS_ADDR, 8'h00);
    wb(1'b1, lfosc_pkg::XO_CTRL_ADDR, 8'h03);
    wb(1'b0, lfosc_pkg::XO_CTRL_ADDR, 8'h00);
    chk("stale key", 32'h0, rd);
  endtask
  task automatic t_ulp();
    int xe, te;
    // cold start: two start-up ticks come before the four gate ticks
    align();
    ulp_request_in <= 1'b1;
    wait_high(1'b0, xe, te);
    chk("ulp cold ticks", 32'd6, te);
    ulp_request_in <= 1'b0;
    @(posedge sys_clk_in);
    prot(lfosc_pkg::ULP_CTRL_ADDR, 8'h02);
    chk("ulp run", 32'h1, {31'h0, ulp_run_out});
    chk("ulp gate", 32'h0, {31'h0, ulp_clk_gate_out});
    align();
    ulp_request_in <= 1'b1;
    wait_high(1'b0, xe, te);
    chk("ulp ticks", 32'd4, te);
    ulp_request_in <= 1'b0;
  endtask
  task automatic t_xo(input logic [1:0] cs, input logic sel);
    logic [7:0] v;
    int xe, te, n;
    v = {2'h0, cs, 1'b0, sel, 2'h0};
    wb(1'b1, lfosc_pkg::XO_CTRL_ADDR, v);
    prot(lfosc_pkg::XO_CTRL_ADDR, v | 8'h01);
    align();
    xo_request_in <= 1'b1;
    wait_high(1'b1, xe, te);
    n = sel ? 0 : 4 * int'(cs) + 4; // counts set on the instance
    chk("xo edges", 32'h1, {31'h0, xe >= n + 2 && xe <= n + 3});
    wb(1'b0, lfosc_pkg::STATUS_ADDR, 8'h00);
    chk("stable", 32'h40, rd & 32'h40);
    // locked fields and reserved bits must not move
    wb(1'b1, lfosc_pkg::XO_CTRL_ADDR, (~v & 8'h34) | 8'hc9);
    wb(1'b0, lfosc_pkg::XO_CTRL_ADDR, 8'h00);
    chk("locked write", {24'h0, v | 8'h01}, rd);
    chk("pins taken", 32'h1, {31'h0, pin_override_out});
    xo_request_in <= 1'b0;
    prot(lfosc_pkg::XO_CTRL_ADDR, v);
    wb(1'b0, lfosc_pkg::STATUS_ADDR, 8'h00);
    chk("unstable", 32'h0, rd & 32'h40);
    chk("pins freed", 32'h0, {31'h0, pin_override_out});
  endtask
  task automatic t_stby();
    prot(lfosc_pkg::XO_CTRL_ADDR, 8'h03);
    sleep_mode_in <= lfosc_pkg::MODE_STANDBY;
    wb(1'b0, lfosc_pkg::STATUS_ADDR, 8'h00);
    chk("stby stable", 32'h0, rd & 32'h40);
    chk("stby run", 32'h1, {31'h0, xo_run_out});
    chk("stby gate", 32'h0, {31'h0, xo_clk_gate_out});
    sleep_mode_in <= lfosc_pkg::MODE_PDOWN;
    repeat (3) @(posedge sys_clk_in);
    chk("pdown run", 32'h0, {31'h0, xo_run_out});
    sleep_mode_in <= lfosc_pkg::MODE_ACTIVE;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    t_regs();
    t_ulp();
    for (int c = 0; c < 4; c++) t_xo(c[1:0], 1'b0);
    t_xo(2'h3, 1'b1);
    t_stby();
    final_report();
  end
endmodule
